// file: tcs_timer_clock_capture.sv
// Counter clock selection, channel input stage and capture registers.
// Assumes pins arrive asynchronous to ref_clk; registers on a plain port.
// How it works
// - Slave mode 000 clocks the counter from the internal clock.
// - Enable and direction change by software only; update generate self-clears.
// - Counter run gate follows counter enable one clock later.
// - Slave mode 111 counts active edges of the selected trigger.
// - Input select 01 picks own pin; channel 2 at 10 picks pin 1.
// - Filter 0000 passes; 0011 needs 8 equal samples at clock rate.
// - Capture prescaler skips trigger path; 00 captures every active edge.
// - Polarity 0 detects rising edges, 1 detects falling edges.
// - Trigger 110 is channel 2 input, 101 channel 1 edge; mode 100 resets.
// - Each trigger edge counts once and, unless slave mode is 000 with external clock enable clear, sets trigger flag, after synchronising.
// - External trigger clock enable selects external clock mode 2.
// - External source: 00 clock, 01 1 kHz, 10 32 kHz, 11 pin.
// - Source 11 with mask enable ANDs clock pin with mask pin.
// - Trigger prescale 01 halves; filter 0000 off; polarity 0 rising.
// - Each channel has buffer and shadow; software sees only buffer.
// - Capture goes shadow then buffer; compare copies buffer to shadow.
// - Compare reference is active high; polarity may invert the output.
// - Capture latches counter, sets channel flag, requests interrupt if enabled.
// - Capture while channel flag set raises missed-capture flag.
// - Flag clears by write 1 or value read; missed flag by write 1.
// - Input select not 00 makes channel input, value read-only.
// - Captures happen only with the channel capture enable set.
// - Capture generate bit sets that channel's flag, raising its capture interrupt request if enabled.
`timescale 1ns/10ps
module tcs_timer_clock_capture
   import tcs_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          resetn,
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [DW-1:0] reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [DW-1:0] reg_rdata,
   input  wire logic          channel1_input_pin,
   input  wire logic          channel2_input_pin,
   input  wire logic          external_clock_pin,
   input  wire logic          clock_mask_pin,
   input  wire logic          rc_1khz_clock,
   input  wire logic          opt_32khz_clock,
   output logic      [1:0]    compare_output,
   output logic      [1:0]    capture_irq
);

   // Filter length in samples for a filter code
   function automatic logic [4:0] filt_len(input logic [3:0] f);
      unique case (f)
         FLT_OFF: filt_len = 5'h01;
         4'h1:    filt_len = 5'h02;
         4'h2:    filt_len = 5'h04;
         FLT_N8:  filt_len = FLT_LEN_N8;
         default: filt_len = {f, 1'b0};
      endcase
   endfunction

   // True when an edge count hits the divide-by-2^ps point
   function automatic logic div_hit(input logic [2:0] c, input logic [1:0] ps);
      logic [2:0] m;
      m = 3'((4'h1 << ps) - 4'h1);
      div_hit = (c & m) == 3'h0;
   endfunction

   // Software-visible registers and the counter
   logic [15:0]   cr1_q;
   logic [15:0]   smcr_q;
   logic [15:0]   ccmr_q;
   logic [15:0]   ccer_q;
   logic [15:0]   cfg_q;
   logic [15:0]   or_q;
   logic [15:0]   cnt_q;
   // Per-channel flags and the capture copy pulse
   logic [1:0]    ccf_q;
   logic [1:0]    miss_q;
   logic [1:0]    copy_q;
   logic          tif_q;
   logic          run_q;
   // Capture register pairs and prescaler state
   logic [15:0]   buf_q [NCH];
   logic [15:0]   shd_q [NCH];
   logic [2:0]    icp_q [NCH];
   logic [2:0]    etp_cnt_q;
   // Synchroniser stages and filter state
   logic [5:0]    s1_q;
   logic [5:0]    s2_q;
   logic [2:0]    flt_q;
   logic [2:0]    prev_q;
   logic [4:0]    fcnt_q [3];

   // Decoded fields; event register bits act only in their write cycle
   logic [2:0] sms;
   logic [2:0] ts;
   logic [1:0] ext_sel;
   logic [1:0] etps;
   logic       ece;
   logic       cen;
   logic       dir;
   logic       wr_egr;
   logic       ug;
   logic [1:0] ccg;
   assign sms     = smcr_q[SMS_LSB +: 3];
   assign ts      = smcr_q[TS_LSB +: 3];
   assign etps    = smcr_q[ETPS_LSB +: 2];
   assign ece     = smcr_q[ECE_B];
   assign ext_sel = or_q[EXTSEL_LSB +: 2];
   assign cen     = cr1_q[CEN_B];
   assign dir     = cr1_q[DIR_B];
   assign wr_egr  = reg_wr && reg_addr == OFS_EGR;
   assign ug      = wr_egr && reg_wdata[UG_B];
   assign ccg     = wr_egr ? reg_wdata[CCG_B +: 2] : 2'h0;

   // Two-stage synchronisers on every pin and foreign clock
   // Only the second stage is read, so metastability never reaches logic
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
      end else begin
         s1_q <= {opt_32khz_clock, rc_1khz_clock, clock_mask_pin,
                  external_clock_pin, channel2_input_pin, channel1_input_pin};
         s2_q <= s1_q;
      end
   end

   // External trigger source, gating and polarity
   // Source 00 has no level; its prescaler then sees an edge every cycle
   logic etr_lvl;
   always_comb begin
      unique case (ext_sel)
         EXT_RC1K: etr_lvl = s2_q[4];
         EXT_32K:  etr_lvl = s2_q[5];
         EXT_PIN:  etr_lvl = s2_q[2] & (s2_q[3] | ~or_q[MSKEN_B]);
         default:  etr_lvl = 1'b0;
      endcase
      etr_lvl = etr_lvl ^ smcr_q[ETP_B];
   end

   // Per-input filter code and level: ch1, ch2, external trigger
   logic [2:0] fin;
   logic [3:0] fcode [3];
   assign fin = {etr_lvl, s2_q[1], s2_q[0]};
   assign fcode[0] = ccmr_q[ICF_LSB +: 4];
   assign fcode[1] = ccmr_q[CCMR_STRIDE + ICF_LSB +: 4];
   assign fcode[2] = smcr_q[ETF_LSB +: 4];

   // Digital filters: output follows after N samples at the new level
   // A run broken by the old level restarts, so short glitches never pass
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flt_q  <= 3'h0;
         prev_q <= 3'h0;
         for (int i = 0; i < 3; i++) fcnt_q[i] <= 5'h00;
      end else begin
         prev_q <= flt_q;
         for (int i = 0; i < 3; i++) begin
            if (fin[i] == flt_q[i]) begin
               fcnt_q[i] <= 5'h00;
            end else if (fcnt_q[i] + 5'h01 >= filt_len(fcode[i])) begin
               flt_q[i]  <= fin[i];
               fcnt_q[i] <= 5'h00;
            end else begin
               fcnt_q[i] <= fcnt_q[i] + 5'h01;
            end
         end
      end
   end

   // Edge detection with per-channel polarity
   logic [2:0] rise;
   logic [2:0] fall;
   logic [1:0] pol;
   logic [1:0] cce;
   logic [1:0] ccs [NCH];
   logic [1:0] icps [NCH];
   logic [1:0] ic_edge;
   logic [1:0] cap_hit;
   // Trigger and clock-tick nets
   logic       ch1_edge;
   logic       ch2_edge;
   logic       trig;
   logic       etr_edge;
   logic       prescaled_external_trigger;
   logic       tick;
   assign rise = flt_q & ~prev_q;
   assign fall = ~flt_q & prev_q;
   always_comb begin
      for (int k = 0; k < NCH; k++) begin
         pol[k]  = ccer_q[k*CCER_STRIDE + CCP_B];
         cce[k]  = ccer_q[k*CCER_STRIDE + CCE_B];
         ccs[k]  = ccmr_q[k*CCMR_STRIDE + CCS_LSB +: 2];
         icps[k] = ccmr_q[k*CCMR_STRIDE + ICPS_LSB +: 2];
         unique case (ccs[k])
            CCS_OWN:   ic_edge[k] = pol[k] ? fall[k] : rise[k];
            CCS_CROSS: ic_edge[k] = pol[k] ? fall[1-k] : rise[1-k];
            default:   ic_edge[k] = 1'b0;
         endcase
         cap_hit[k] = ccs[k] != CCS_OUT && cce[k] && ic_edge[k]
                      && div_hit(icp_q[k], icps[k]);
      end
   end
   assign ch1_edge = pol[0] ? fall[0] : rise[0];
   assign ch2_edge = pol[1] ? fall[1] : rise[1];
   // Trigger selection takes no capture prescale
   assign trig = (ts == TS_CH1_EDGE) ? ch1_edge :
                 (ts == TS_CH2_IN)   ? ch2_edge : 1'b0;
   assign etr_edge = (ext_sel == EXT_PCLK) ? 1'b1 : rise[2];
   assign prescaled_external_trigger = etr_edge && div_hit(etp_cnt_q, etps);
   // Counter clock source
   assign tick = ece ? prescaled_external_trigger :
                 (sms == SMS_EXT1) ? trig : 1'b1;

   // External trigger prescaler
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) etp_cnt_q <= 3'h0;
      else if (etr_edge) etp_cnt_q <= etp_cnt_q + 3'h1;
   end

   // Counter run gate lags the enable bit by one clock
   // Counting starts one clock after software sets the enable
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) run_q <= 1'b0;
      else run_q <= cen;
   end

   // Counter
   // Update generate and a trigger reset outrank a software write
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= RST_REG;
      end else if (ug || (sms == SMS_RESET && trig)) begin
         cnt_q <= 16'h0000;
      end else if (reg_wr && reg_addr == OFS_CNT) begin
         cnt_q <= reg_wdata;
      end else if (run_q && tick) begin
         cnt_q <= dir ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
      end
   end

   // Control registers written by software only
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cr1_q  <= RST_REG;
         smcr_q <= RST_REG;
         ccmr_q <= RST_REG;
         ccer_q <= RST_REG;
         cfg_q  <= RST_REG;
         or_q   <= RST_REG;
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_CR1:   cr1_q  <= reg_wdata;
            OFS_SMCR:  smcr_q <= reg_wdata;
            OFS_CCMR1: ccmr_q <= reg_wdata;
            OFS_CCER:  ccer_q <= reg_wdata;
            OFS_CFG:   cfg_q  <= reg_wdata;
            OFS_OR:    or_q   <= reg_wdata;
            default:   ;
         endcase
      end
   end

   // Capture prescalers count channel edges
   // Only enabled channels advance, so the first enabled edge captures
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int k = 0; k < NCH; k++) icp_q[k] <= 3'h0;
      end else begin
         for (int k = 0; k < NCH; k++)
            if (ic_edge[k] && cce[k]) icp_q[k] <= icp_q[k] + 3'h1;
      end
   end

   // Shadow and buffer registers per channel
   // The buffer takes the shadow a cycle later, so a read never sees a half capture
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         copy_q <= 2'h0;
         for (int k = 0; k < NCH; k++) begin
            shd_q[k] <= RST_REG;
            buf_q[k] <= RST_REG;
         end
      end else begin
         copy_q <= cap_hit;
         for (int k = 0; k < NCH; k++) begin
            if (ccs[k] == CCS_OUT) begin
               shd_q[k] <= buf_q[k];
               if (reg_wr && reg_addr == OFS_CCR1 + 4'(k))
                  buf_q[k] <= reg_wdata;
            end else begin
               if (cap_hit[k]) shd_q[k] <= cnt_q;
               if (copy_q[k]) buf_q[k] <= shd_q[k];
            end
         end
      end
   end

   // Flags: a setting event wins over a clear in the same cycle
   // A miss compares with the flag as it stood before this cycle's clear
   logic [1:0] ccr_rd;
   logic [1:0] ccf_clr;
   logic [1:0] miss_clr;
   assign ccr_rd   = {reg_rd && reg_addr == OFS_CCR2, reg_rd && reg_addr == OFS_CCR1};
   assign ccf_clr  = (reg_wr && reg_addr == OFS_FLAG) ? reg_wdata[CCF_B +: 2] : 2'h0;
   assign miss_clr = (reg_wr && reg_addr == OFS_MISS) ? reg_wdata[CCF_B +: 2] : 2'h0;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ccf_q  <= 2'h0;
         miss_q <= 2'h0;
         tif_q  <= 1'b0;
      end else begin
         ccf_q  <= copy_q | ccg | (ccf_q & ~ccf_clr & ~ccr_rd);
         miss_q <= (copy_q & ccf_q) | (miss_q & ~miss_clr);
         if ((sms != SMS_OFF || ece) && trig)
            tif_q <= 1'b1;
         else if (reg_wr && reg_addr == OFS_FLAG && reg_wdata[TIF_B])
            tif_q <= 1'b0;
      end
   end

   // Compare reference and output pins, capture requests
   // Reference is high while the counter is below the shadow value
   logic [1:0] cref;
   always_comb begin
      for (int k = 0; k < NCH; k++)
         cref[k] = ccs[k] == CCS_OUT && cnt_q < shd_q[k];
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         compare_output <= 2'h0;
         capture_irq    <= 2'h0;
      end else begin
         compare_output <= cce & (cref ^ pol);
         capture_irq    <= ccf_q & cfg_q[CCF_B +: 2];
      end
   end

   // Status words for the read port, each flag at its own bit
   logic [15:0] flag_word;
   logic [15:0] miss_word;
   always_comb begin
      flag_word = 16'h0000;
      flag_word[TIF_B] = tif_q;
      flag_word[CCF_B +: 2] = ccf_q;
      miss_word = 16'h0000;
      miss_word[CCF_B +: 2] = miss_q;
   end

   // Register read port, data one cycle after the strobe
   // Captured values come from the buffer; the shadow is never visible
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_CR1:   reg_rdata <= cr1_q;
            OFS_SMCR:  reg_rdata <= smcr_q;
            OFS_CCMR1: reg_rdata <= ccmr_q;
            OFS_CCER:  reg_rdata <= ccer_q;
            OFS_CNT:   reg_rdata <= cnt_q;
            OFS_CCR1:  reg_rdata <= buf_q[0];
            OFS_CCR2:  reg_rdata <= buf_q[1];
            OFS_FLAG:  reg_rdata <= flag_word;
            OFS_MISS:  reg_rdata <= miss_word;
            OFS_CFG:   reg_rdata <= cfg_q;
            OFS_OR:    reg_rdata <= or_q;
            default:   reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

// file: tcs_pkg.sv
// Constants for the timer clock select and input capture block.
// Assumes a 16-bit register port with 4-bit word addresses.
package tcs_pkg;
   localparam int AW = 4;
   localparam int DW = 16;
   localparam int NCH = 2;
   // Register word addresses
   localparam logic [3:0] OFS_CR1   = 4'h0;
   localparam logic [3:0] OFS_EGR   = 4'h1;
   localparam logic [3:0] OFS_SMCR  = 4'h2;
   localparam logic [3:0] OFS_CCMR1 = 4'h3;
   localparam logic [3:0] OFS_CCER  = 4'h4;
   localparam logic [3:0] OFS_CNT   = 4'h5;
   localparam logic [3:0] OFS_CCR1  = 4'h6;
   localparam logic [3:0] OFS_CCR2  = 4'h7;
   localparam logic [3:0] OFS_FLAG  = 4'h8;
   localparam logic [3:0] OFS_MISS  = 4'h9;
   localparam logic [3:0] OFS_CFG   = 4'ha;
   localparam logic [3:0] OFS_OR    = 4'hb;
   // Field positions
   localparam int CEN_B = 0;
   localparam int DIR_B = 1;
   localparam int UG_B = 0;
   localparam int CCG_B = 1;
   localparam int SMS_LSB = 0;
   localparam int TS_LSB = 4;
   localparam int ETF_LSB = 8;
   localparam int ETPS_LSB = 12;
   localparam int ECE_B = 14;
   localparam int ETP_B = 15;
   localparam int CCMR_STRIDE = 8;
   localparam int CCS_LSB = 0;
   localparam int ICPS_LSB = 2;
   localparam int ICF_LSB = 4;
   localparam int CCER_STRIDE = 4;
   localparam int CCE_B = 0;
   localparam int CCP_B = 1;
   localparam int CCF_B = 1;
   localparam int TIF_B = 6;
   localparam int EXTSEL_LSB = 0;
   localparam int MSKEN_B = 2;
   // Reset value of every register
   localparam logic [15:0] RST_REG = 16'h0000;
   // Encodings
   localparam logic [2:0] SMS_OFF = 3'h0;
   localparam logic [2:0] SMS_RESET = 3'h4;
   localparam logic [2:0] SMS_EXT1 = 3'h7;
   localparam logic [2:0] TS_CH1_EDGE = 3'h5;
   localparam logic [2:0] TS_CH2_IN = 3'h6;
   localparam logic [1:0] CCS_OUT = 2'h0;
   localparam logic [1:0] CCS_OWN = 2'h1;
   localparam logic [1:0] CCS_CROSS = 2'h2;
   localparam logic [1:0] EXT_PCLK = 2'h0;
   localparam logic [1:0] EXT_RC1K = 2'h1;
   localparam logic [1:0] EXT_32K = 2'h2;
   localparam logic [1:0] EXT_PIN = 2'h3;
   localparam logic [3:0] FLT_OFF = 4'h0;
   localparam logic [3:0] FLT_N8 = 4'h3;
   localparam logic [4:0] FLT_LEN_N8 = 5'h08;
endpackage

// file: tcs_timer_clock_capture_chk.sv
// Port checker for the timer clock select and input capture block.
// Bound to the design in the testbench top; sees design ports only.
`timescale 1ns/10ps
module tcs_timer_clock_capture_chk
   import tcs_pkg::*;
(
   input wire logic          ref_clk,
   input wire logic          resetn,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [DW-1:0] reg_rdata,
   input wire logic [1:0]    compare_output,
   input wire logic [1:0]    capture_irq
);
   logic [1:0] en_m;
   logic [1:0] cce_m;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Mirror of interrupt enables and channel enables as software wrote them
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         en_m  <= 2'h0;
         cce_m <= 2'h0;
      end else if (reg_wr) begin
         if (reg_addr == OFS_CFG) en_m <= reg_wdata[2:1];
         if (reg_addr == OFS_CCER) cce_m <= {reg_wdata[4], reg_wdata[0]};
      end
   end
   // Read data only in the cycle after a read strobe
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_egr_reads_zero: assert property (reg_rd && reg_addr == OFS_EGR |=> reg_rdata == 16'h0000)
      else $error("event register read not zero");
   a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_OR |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_irq_masked: assert property (reg_wr && reg_addr == OFS_CFG && reg_wdata[2:1] == 2'h0
      |-> ##2 capture_irq == 2'h0)
      else $error("request stays after masking");
   a_irq_needs_en: assert property (!$past(en_m[1]) |-> !capture_irq[1])
      else $error("request without enable");
   a_irq_generate: assert property (reg_wr && reg_addr == OFS_EGR && reg_wdata[CCG_B] && en_m[0]
      |-> ##[1:4] capture_irq[0])
      else $error("capture generate gave no request");
   a_flag_wr_clear: assert property (reg_wr && reg_addr == OFS_FLAG && reg_wdata[CCF_B]
      |-> ##2 !capture_irq[0])
      else $error("flag write did not clear");
   a_flag_rd_clear: assert property (reg_rd && reg_addr == OFS_CCR1 |-> ##2 !capture_irq[0])
      else $error("value read did not clear flag");
   a_out_enable: assert property (!$past(cce_m[0]) |-> !compare_output[0])
      else $error("compare output while disabled");
   // Main scenarios reached
   c_irq_ch1: cover property ($rose(capture_irq[0]));
   c_irq_ch2: cover property ($rose(capture_irq[1]));
   c_cmp_out: cover property (compare_output[0]);
endmodule

// file: tcs_pin_model.sv
// Model of the pins and slow clocks around the timer.
// Assumes the testbench calls its tasks just after a rising edge.
`timescale 1ns/10ps
module tcs_pin_model (
   input  wire logic       ref_clk,
   output logic      [5:0] pins
);
   // All pins idle low
   initial pins = 6'h00;
   // One high pulse on pin idx, then a low stretch
   task automatic pulse(input int idx, input int hi, input int lo);
      @(posedge ref_clk);
      pins[idx] <= 1'b1;
      repeat (hi) @(posedge ref_clk);
      pins[idx] <= 1'b0;
      repeat (lo) @(posedge ref_clk);
   endtask
   // Static level, used for the mask pin
   task automatic level(input int idx, input logic v);
      @(posedge ref_clk);
      pins[idx] <= v;
   endtask
endmodule

// file: tcs_timer_clock_capture_tb.sv
// Testbench for the timer clock select and input capture block.
// Drives the register port and pins; the checker is bound below.
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("[ERR] %s exp %h got %h", n, e, g); \
   end \
end
module tcs_timer_clock_capture_tb;
   import tcs_pkg::*;
   logic          ref_clk;
   logic          resetn;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [DW-1:0] reg_rdata;
   logic [5:0]    pins;
   logic [1:0]    compare_output;
   logic [1:0]    capture_irq;
   int            fails;
   int            cmp_count;
   tcs_pin_model pm (.ref_clk(ref_clk), .pins(pins));
   tcs_timer_clock_capture DUT (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .channel1_input_pin(pins[0]), .channel2_input_pin(pins[1]),
      .external_clock_pin(pins[2]), .clock_mask_pin(pins[3]), .rc_1khz_clock(pins[4]),
      .opt_32khz_clock(pins[5]), .compare_output(compare_output), .capture_irq(capture_irq));
   // 125 MHz clock
   always #4 ref_clk = ~ref_clk;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // One-cycle read strobe, data taken in the following cycle
   task automatic rc(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK($sformatf("reg %h", a), e, reg_rdata)
   endtask
   // Bounded wait for the channel 1 request
   task automatic wait_irq();
      int n;
      n = 0;
      while (capture_irq[0] !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (capture_irq[0] !== 1'b1) begin
         fails++;
         report_and_stop();
      end
   endtask
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      fails = 0;
      cmp_count = 0;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int a = 0; a < 16; a++) rc(4'(a), RST_REG);
      wr(OFS_CR1, 16'h0001);
      wr(OFS_CR1, 16'h0000);
      rc(OFS_CNT, 16'h0002);
      wr(OFS_EGR, 16'h0001);
      rc(OFS_CNT, 16'h0000);
      wr(OFS_CR1, 16'h0003);
      wr(OFS_CR1, 16'h0002);
      rc(OFS_CNT, 16'hfffe);
      wr(OFS_EGR, 16'h0001);
      wr(OFS_CCMR1, 16'h0100);
      wr(OFS_SMCR, 16'h0067);
      wr(OFS_CR1, 16'h0001);
      for (int i = 0; i < 3; i++) pm.pulse(1, 6, 6);
      rc(OFS_CNT, 16'h0003);
      rc(OFS_FLAG, 16'h0040);
      wr(OFS_FLAG, 16'h0040);
      wr(OFS_SMCR, 16'h5000);
      wr(OFS_OR, 16'h0007);
      wr(OFS_EGR, 16'h0001);
      pm.level(3, 1'b1);
      for (int i = 0; i < 4; i++) pm.pulse(2, 4, 4);
      pm.level(3, 1'b0);
      for (int i = 0; i < 4; i++) pm.pulse(2, 4, 4);
      rc(OFS_CNT, 16'h0002);
      for (int s = 1; s < 3; s++) begin
         wr(OFS_OR, 16'(s));
         wr(OFS_EGR, 16'h0001);
         for (int i = 0; i < 4; i++) pm.pulse(3 + s, 4, 4);
         rc(OFS_CNT, 16'h0002);
      end
      wr(OFS_CR1, 16'h0000);
      wr(OFS_SMCR, 16'h0000);
      wr(OFS_OR, 16'h0000);
      wr(OFS_CNT, 16'h0042);
      wr(OFS_CCMR1, 16'h0201);
      wr(OFS_CCER, 16'h0031);
      wr(OFS_CFG, 16'h0006);
      pm.pulse(0, 6, 12);
      rc(OFS_FLAG, 16'h0006);
      rc(OFS_CCR2, 16'h0042);
      wr(OFS_CNT, 16'h0043);
      pm.pulse(0, 6, 12);
      rc(OFS_MISS, 16'h0002);
      rc(OFS_CCR1, 16'h0043);
      rc(OFS_FLAG, 16'h0004);
      wr(OFS_MISS, 16'h0002);
      rc(OFS_MISS, 16'h0000);
      wr(OFS_CCR1, 16'h1234);
      rc(OFS_CCR1, 16'h0043);
      wr(OFS_FLAG, 16'h0004);
      rc(OFS_FLAG, 16'h0000);
      wr(OFS_CCER, 16'h0000);
      pm.pulse(0, 6, 12);
      rc(OFS_FLAG, 16'h0000);
      wr(OFS_CCER, 16'h0001);
      wr(OFS_CCMR1, 16'h0031);
      pm.pulse(0, 5, 14);
      rc(OFS_FLAG, 16'h0000);
      pm.pulse(0, 10, 14);
      rc(OFS_FLAG, 16'h0002);
      wr(OFS_FLAG, 16'h0002);
      wr(OFS_EGR, 16'h0002);
      wait_irq();
      `CHK("capture_irq", 1'b1, capture_irq[0])
      wr(OFS_FLAG, 16'h0002);
      wr(OFS_CCMR1, 16'h0001);
      wr(OFS_SMCR, 16'h0054);
      wr(OFS_CNT, 16'h0050);
      pm.pulse(0, 6, 12);
      rc(OFS_CNT, 16'h0000);
      wr(OFS_SMCR, 16'h0000);
      wr(OFS_CCMR1, 16'h0000);
      wr(OFS_CCR1, 16'h0010);
      repeat (3) @(posedge ref_clk);
      `CHK("compare_output", 2'h1, compare_output)
      wr(OFS_CCER, 16'h0003);
      repeat (3) @(posedge ref_clk);
      `CHK("compare_output", 2'h0, compare_output)
      `CHK("capture_irq", 2'h1, capture_irq)
      wr(OFS_CFG, 16'h0000);
      repeat (2) @(posedge ref_clk);
      `CHK("capture_irq", 2'h0, capture_irq)
      report_and_stop();
   end
endmodule
bind tcs_timer_clock_capture tcs_timer_clock_capture_chk u_chk (.ref_clk(ref_clk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_output(compare_output),
   .capture_irq(capture_irq));
